// *** hdl/ifgc_counter.sv ***
// gated pulse counter: timed frequency gate and pulse width gate
//
// Functional notes
// [RQ1] software runs only one function at once
// [RQ2] channel select: two bits, 11 prohibited
// [RQ3] counting starts only on start bit write; with gate clock field 11 outside pulse mode the code counts with no start
// [RQ4] clear bit one clears count; zero nothing
// [RQ5] start launches count; status marks gate end
// [RQ6] pulse mode status gives no end indication; the code clears the status when the pulse gate closes too
// [RQ7] one sixteen-bit binary up-counter for both
// [RQ8] frequency mode counts pin only while gated
// [RQ9] direct mode counts edges; halved mode halves
// [RQ10] pulse mode counts reference clock while gated
// [RQ11] count saturates at all ones until cleared
// [RQ12] count readable through data read port
// [RQ13] registers zero at reset; soft resets clear; on clock stop the code keeps the upper function bit
// [RQ14] timed gate 1/4/8 ms from next tick
// [RQ15] pulse gate from one rising edge to next
// [RQ16] gate clock field picks time or reference
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ifgc_params.svh"
module ifgc_counter #(
    parameter int unsigned CYC_1K = `IFGC_CYC_1K,
    parameter int unsigned CYC_100K = `IFGC_CYC_100K,
    parameter int unsigned CYC_900K = `IFGC_CYC_900K,
    parameter int unsigned COUNT_W = `IFGC_COUNT_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ifgc_pkg::ifgc_bus_req_type busReq,
    output logic [`IFGC_DATA_W-1:0] readData,
    input wire logic watchdogReset,
    input wire logic chipEnableReset,
    input wire logic clockStop,
    input wire logic fm_freq_input,
    input wire logic am_freq_input,
    input wire logic gate_pulse_pin0,
    input wire logic gate_pulse_pin1,
    output logic gateOpen,
    output logic gatePin0Used,
    output logic gatePin1Used
);
    import ifgc_pkg::*;

    initial begin
        if (COUNT_W != `IFGC_COUNT_W) begin
            $error("ifgc_counter: counter must be sixteen bits wide");
        end
        if (CYC_1K < CYC_100K || CYC_100K < CYC_900K) begin
            $error("ifgc_counter: reference periods out of order");
        end
    end

    function automatic logic [3:0] gate_ticks(input logic [1:0] gclk);
        case (gclk)
            2'h0: gate_ticks = `IFGC_GATE_1MS;
            2'h1: gate_ticks = `IFGC_GATE_4MS;
            default: gate_ticks = `IFGC_GATE_8MS;
        endcase
    endfunction : gate_ticks

    // register write decode, shared by every writable offset
    function automatic logic wr_hit(input ifgc_bus_req_type req,
        input logic [`IFGC_ADDR_W-1:0] ofs);
        wr_hit = req.wr && (req.addr == ofs);
    endfunction : wr_hit

    // reference ticks
    logic tick1k;
    logic tick100k;
    logic tick900k;

    ifgc_tick_gen #(.PERIOD(CYC_1K)) u_tick1k (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick1k)
    );
    ifgc_tick_gen #(.PERIOD(CYC_100K)) u_tick100k (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick100k)
    );
    ifgc_tick_gen #(.PERIOD(CYC_900K)) u_tick900k (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick900k)
    );

    // input edge detection
    logic [3:0] pinPrev;
    logic [3:0] next_pinPrev;
    logic fmRise;
    logic amRise;
    logic pin0Rise;
    logic pin1Rise;

    always_comb begin
        next_pinPrev = {gate_pulse_pin1, gate_pulse_pin0, am_freq_input, fm_freq_input};
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinPrev <= 4'h0;
        end else begin
            pinPrev <= next_pinPrev;
        end
    end

    assign fmRise = fm_freq_input & ~pinPrev[0];
    assign amRise = am_freq_input & ~pinPrev[1];
    assign pin0Rise = gate_pulse_pin0 & ~pinPrev[2];
    assign pin1Rise = gate_pulse_pin1 & ~pinPrev[3];

    // register file
    logic [1:0] chanSel;
    logic [1:0] next_chanSel;
    ifgc_mode_type modeSel;
    ifgc_mode_type next_modeSel;
    logic [`IFGC_DATA_W-1:0] next_readData;
    logic next_gatePin0Used;
    logic next_gatePin1Used;
    logic startPulse;
    logic clearPulse;
    logic softReset;
    logic wrCtl;
    logic [COUNT_W-1:0] count;
    ifgc_state_type state;

    assign softReset = watchdogReset | chipEnableReset;
    assign wrCtl = wr_hit(busReq, `IFGC_OFS_CONTROL);
    assign startPulse = wrCtl && busReq.wdata[`IFGC_CTL_START_POS]; // [RQ3]
    assign clearPulse = wrCtl && busReq.wdata[`IFGC_CTL_CLEAR_POS]; // [RQ4]

    always_comb begin
        next_chanSel = chanSel;
        next_modeSel = modeSel;
        if (wr_hit(busReq, `IFGC_OFS_CHAN_SEL)) begin
            next_chanSel = busReq.wdata[1:0]; // [RQ2]
        end
        if (wr_hit(busReq, `IFGC_OFS_MODE_SEL)) begin
            next_modeSel = busReq.wdata[3:0]; // [RQ16]
        end
        if (softReset) begin
            next_chanSel = `IFGC_CHAN_SEL_RST; // [RQ13]
            next_modeSel = `IFGC_MODE_SEL_RST;
        end else if (clockStop) begin
            next_chanSel = `IFGC_CHAN_SEL_RST; // [RQ13]
            next_modeSel = {modeSel.func[1], 3'h0};
        end
        // pin use follows the values about to be registered
        next_gatePin0Used = (next_modeSel.func == `IFGC_FUNC_PULSE)
            && (next_chanSel == `IFGC_CHAN_PIN0);
        next_gatePin1Used = (next_modeSel.func == `IFGC_FUNC_PULSE)
            && (next_chanSel == `IFGC_CHAN_PIN1);
        // unmapped and write-only offsets read as zero
        next_readData = '0;
        if (busReq.rd) begin
            case (busReq.addr)
                `IFGC_OFS_CHAN_SEL: next_readData = {14'h0000, chanSel}; // [RQ2]
                `IFGC_OFS_GATE_STAT: next_readData = {15'h0000, gateOpen}; // [RQ5]
                `IFGC_OFS_MODE_SEL: next_readData = {12'h000, modeSel};
                `IFGC_OFS_COUNT: next_readData = count; // [RQ12]
                default: next_readData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chanSel <= `IFGC_CHAN_SEL_RST; // [RQ13]
            modeSel <= `IFGC_MODE_SEL_RST;
            readData <= '0;
            gatePin0Used <= 1'b0;
            gatePin1Used <= 1'b0;
        end else begin
            chanSel <= next_chanSel;
            modeSel <= next_modeSel;
            readData <= next_readData;
            gatePin0Used <= next_gatePin0Used;
            gatePin1Used <= next_gatePin1Used;
        end
    end

    // gate control
    ifgc_state_type next_state;
    logic [3:0] msLeft;
    logic [3:0] next_msLeft;
    logic next_gateOpen;
    logic pulseFunc;
    logic openGate;
    logic selPinRise;
    logic gateLive;

    assign pulseFunc = (modeSel.func == `IFGC_FUNC_PULSE); // [RQ1]
    assign openGate = !pulseFunc && (modeSel.gclk == `IFGC_GCLK_OPEN);
    assign selPinRise = (chanSel == `IFGC_CHAN_PIN0) ? pin0Rise :
        (chanSel == `IFGC_CHAN_PIN1) ? pin1Rise : 1'b0; // [RQ2]

    always_comb begin
        next_state = state;
        next_msLeft = msLeft;
        case (state)
            ST_IDLE: begin
                if (startPulse && !openGate) begin
                    next_state = pulseFunc ? ST_PW_WAIT : ST_WAIT_TICK; // [RQ3]
                end
            end
            ST_WAIT_TICK: begin
                if (tick1k) begin
                    next_state = ST_IF_OPEN; // [RQ14]
                    next_msLeft = gate_ticks(modeSel.gclk); // [RQ16]
                end
            end
            ST_IF_OPEN: begin
                if (tick1k) begin
                    next_msLeft = msLeft - 4'd1;
                    if (msLeft == 4'd1) begin
                        next_state = ST_IDLE; // [RQ14]
                    end
                end
            end
            ST_PW_WAIT: begin
                if (selPinRise) begin
                    next_state = ST_PW_OPEN; // [RQ15]
                end
            end
            ST_PW_OPEN: begin
                if (selPinRise) begin
                    next_state = ST_IDLE; // [RQ15]
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (softReset || clockStop || (state != ST_IDLE && openGate)) begin
            next_state = ST_IDLE;
        end
        // status holds from start until the gate closes, in both functions
        next_gateOpen = (next_state != ST_IDLE); // [RQ5] [RQ6]
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            msLeft <= 4'h0;
            gateOpen <= 1'b0;
        end else begin
            state <= next_state;
            msLeft <= next_msLeft;
            gateOpen <= next_gateOpen;
        end
    end

    // counting
    logic halfPhase;
    logic next_halfPhase;
    logic [COUNT_W-1:0] next_count;
    logic countEvent;
    logic refTick;

    always_comb begin
        case (modeSel.gclk)
            2'h0: refTick = tick1k; // [RQ16]
            2'h1: refTick = tick100k;
            2'h2: refTick = tick900k;
            default: refTick = 1'b0;
        endcase
        gateLive = (state == ST_IF_OPEN) || openGate; // [RQ8]
        next_halfPhase = halfPhase;
        countEvent = 1'b0;
        if (pulseFunc) begin
            countEvent = (state == ST_PW_OPEN) && refTick; // [RQ10]
        end else if (gateLive) begin
            case (modeSel.func)
                `IFGC_FUNC_AM: countEvent = amRise; // [RQ9]
                `IFGC_FUNC_FM_HALF: begin
                    countEvent = fmRise && halfPhase; // [RQ9]
                    next_halfPhase = halfPhase ^ fmRise;
                end
                default: countEvent = fmRise; // [RQ9]
            endcase
        end
        if (startPulse) begin
            next_halfPhase = 1'b0;
        end
        next_count = count;
        if (countEvent && count != `IFGC_COUNT_MAX) begin
            next_count = count + 16'h0001; // [RQ7] [RQ11]
        end
        if (clearPulse) begin
            next_count = `IFGC_COUNT_RST; // [RQ4]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            halfPhase <= 1'b0;
            count <= `IFGC_COUNT_RST;
        end else begin
            halfPhase <= next_halfPhase;
            count <= next_count;
        end
    end
endmodule : ifgc_counter
`default_nettype wire

// *** hdl/ifgc_params.svh ***
// constants of the gated pulse counter: offsets, fields, resets, timing
`ifndef IFGC_PARAMS_SVH
`define IFGC_PARAMS_SVH

`define IFGC_ADDR_W 8
`define IFGC_DATA_W 16
`define IFGC_COUNT_W 16

`define IFGC_OFS_CHAN_SEL 8'h20
`define IFGC_OFS_GATE_STAT 8'h21
`define IFGC_OFS_MODE_SEL 8'h22
`define IFGC_OFS_CONTROL 8'h23
`define IFGC_OFS_COUNT 8'h24

`define IFGC_CTL_CLEAR_POS 0
`define IFGC_CTL_START_POS 1
`define IFGC_STAT_OPEN_POS 0

`define IFGC_CHAN_SEL_RST 2'h0
`define IFGC_MODE_SEL_RST 4'h0
`define IFGC_COUNT_RST 16'h0000
`define IFGC_COUNT_MAX 16'hFFFF

`define IFGC_FUNC_PULSE 2'h0
`define IFGC_FUNC_AM 2'h1
`define IFGC_FUNC_FM_HALF 2'h2
`define IFGC_FUNC_FM_DIRECT 2'h3
`define IFGC_GCLK_OPEN 2'h3
`define IFGC_CHAN_PIN0 2'h1
`define IFGC_CHAN_PIN1 2'h2

`define IFGC_CLK_HZ 100000000
`define IFGC_REF_1K_HZ 1000
`define IFGC_REF_100K_HZ 100000
`define IFGC_REF_900K_HZ 900000
`define IFGC_CYC_1K (`IFGC_CLK_HZ / `IFGC_REF_1K_HZ)
`define IFGC_CYC_100K (`IFGC_CLK_HZ / `IFGC_REF_100K_HZ)
`define IFGC_CYC_900K (`IFGC_CLK_HZ / `IFGC_REF_900K_HZ)
`define IFGC_GATE_1MS 4'd1
`define IFGC_GATE_4MS 4'd4
`define IFGC_GATE_8MS 4'd8

`endif

// *** hdl/ifgc_pkg.sv ***
// types of the gated pulse counter
`include "ifgc_params.svh"
package ifgc_pkg;
    typedef struct packed {
        logic [`IFGC_ADDR_W-1:0] addr;
        logic [`IFGC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ifgc_bus_req_type;

    typedef struct packed {
        logic [1:0] func;
        logic [1:0] gclk;
    } ifgc_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_TICK = 3'b001,
        ST_IF_OPEN = 3'b010,
        ST_PW_WAIT = 3'b011,
        ST_PW_OPEN = 3'b100
    } ifgc_state_type;
endpackage : ifgc_pkg

// *** hdl/ifgc_tick_gen.sv ***
// free running divider giving a one-cycle tick every PERIOD clocks
`timescale 1ns/100ps
`default_nettype none
module ifgc_tick_gen #(
    parameter int unsigned PERIOD = 100
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic tick
);
    localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_tick;

    initial begin
        if (PERIOD < 2) begin
            $error("ifgc_tick_gen: PERIOD must be at least 2");
        end
    end

    always_comb begin
        next_tick = (count == LAST);
        next_count = next_tick ? '0 : count + CW'(1);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : ifgc_tick_gen
`default_nettype wire

// *** sim/ifgc_monitor.sv ***
// checker on the gated pulse counter ports
`timescale 1ns/100ps
`default_nettype none
`include "ifgc_params.svh"
module ifgc_monitor #(
    parameter int unsigned CYC_1K = 200,
    parameter int unsigned CYC_100K = 20,
    parameter int unsigned CYC_900K = 10,
    parameter int unsigned COUNT_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ifgc_pkg::ifgc_bus_req_type busReq,
    input wire logic [`IFGC_DATA_W-1:0] readData,
    input wire logic watchdogReset,
    input wire logic chipEnableReset,
    input wire logic clockStop,
    input wire logic fm_freq_input,
    input wire logic am_freq_input,
    input wire logic gate_pulse_pin0,
    input wire logic gate_pulse_pin1,
    input wire logic gateOpen,
    input wire logic gatePin0Used,
    input wire logic gatePin1Used
);
    import ifgc_pkg::*;
    logic softRst;
    logic startWr;
    assign softRst = watchdogReset || chipEnableReset || clockStop;
    assign startWr = busReq.wr && busReq.addr == `IFGC_OFS_CONTROL && busReq.wdata[1];
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence readOf(logic [7:0] a);
        busReq.rd && busReq.addr == a;
    endsequence
    sequence softPulse;
        softRst ##1 1'b1;
    endsequence
    idle_read_a: assert property (!busReq.rd |=> readData == '0)
        else $error("read data not idle zero");
    chan_upper_a: assert property (readOf(`IFGC_OFS_CHAN_SEL) |=> readData[15:2] == '0)
        else $error("channel upper bits not zero");
    ctl_read_a: assert property (readOf(`IFGC_OFS_CONTROL) |=> readData == '0)
        else $error("control read not zero");
    stat_read_a: assert property (readOf(`IFGC_OFS_GATE_STAT) |=>
        readData == {15'h0000, $past(gateOpen)}) else $error("status read wrong");
    pin_excl_a: assert property (!(gatePin0Used && gatePin1Used))
        else $error("both gate pins in use");
    soft_clear_a: assert property (softPulse |=> !gatePin0Used && !gatePin1Used)
        else $error("gate pin use kept over soft reset");
    soft_abort_a: assert property (softPulse |=> !gateOpen)
        else $error("gate kept over soft reset");
    idle_gate_a: assert property (!gateOpen && !startWr |=> !gateOpen)
        else $error("gate opened without start");
endmodule : ifgc_monitor
bind ifgc_counter ifgc_monitor #(.CYC_1K(CYC_1K), .CYC_100K(CYC_100K), .CYC_900K(CYC_900K),
    .COUNT_W(COUNT_W)) MON (.clk(clk), .sys_rst(sys_rst), .busReq(busReq),
    .readData(readData), .watchdogReset(watchdogReset), .chipEnableReset(chipEnableReset),
    .clockStop(clockStop), .fm_freq_input(fm_freq_input), .am_freq_input(am_freq_input),
    .gate_pulse_pin0(gate_pulse_pin0), .gate_pulse_pin1(gate_pulse_pin1),
    .gateOpen(gateOpen), .gatePin0Used(gatePin0Used), .gatePin1Used(gatePin1Used));
`default_nettype wire

// *** sim/ifgc_source.sv ***
// signal source at the frequency and gate pins
`timescale 1ns/100ps
`default_nettype none
module ifgc_source #(
    parameter int AM_HALF = 2,
    parameter int FM_HALF = 4,
    parameter int P0_HALF = 200,
    parameter int P1_HALF = 300
) (
    input wire logic clk,
    input wire logic run,
    output logic amOut,
    output logic fmOut,
    output logic pin0Out,
    output logic pin1Out
);
    int cnt = 0;
    function automatic logic wave(input int half);
        return run && (cnt / half) % 2 == 1;
    endfunction : wave
    initial {amOut, fmOut, pin0Out, pin1Out} = 4'h0;
    // square waves, low while stopped
    always @(posedge clk) begin
        cnt <= run ? cnt + 1 : 0;
        amOut <= wave(AM_HALF);
        fmOut <= wave(FM_HALF);
        pin0Out <= wave(P0_HALF);
        pin1Out <= wave(P1_HALF);
    end
endmodule : ifgc_source
`default_nettype wire

// *** sim/ifgc_counter_bench.sv ***
// self-checking bench of the gated pulse counter
`timescale 1ns/100ps
`default_nettype none
`include "ifgc_params.svh"
module ifgc_counter_bench;
    import ifgc_pkg::*;
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] chan;
        logic [15:0] lo;
        logic [15:0] hi;
    } ifgc_row_type;
    logic clk;
    logic sys_rst;
    ifgc_bus_req_type busReq;
    logic [15:0] readData;
    logic [2:0] softRst;
    logic run;
    logic fmIn, amIn, pin0, pin1, gateOpen, pin0Used, pin1Used;
    int error_cnt = 0;
    int tests_run = 0;
    ifgc_row_type rows [8] = '{{4'h4, 2'h0, 16'h0031, 16'h0033}, {4'h5, 2'h0, 16'h00C7, 16'h00C9},
        {4'h6, 2'h0, 16'h018F, 16'h0191}, {4'h8, 2'h0, 16'h000B, 16'h000D},
        {4'hC, 2'h0, 16'h0018, 16'h001A}, {4'h0, 2'h1, 16'h0001, 16'h0003},
        {4'h1, 2'h1, 16'h0013, 16'h0015}, {4'h2, 2'h2, 16'h003B, 16'h003D}};
    ifgc_counter #(.CYC_1K(200), .CYC_100K(20), .CYC_900K(10)) DUT (.clk(clk),
        .sys_rst(sys_rst), .busReq(busReq), .readData(readData), .watchdogReset(softRst[0]),
        .chipEnableReset(softRst[1]), .clockStop(softRst[2]), .fm_freq_input(fmIn),
        .am_freq_input(amIn), .gate_pulse_pin0(pin0), .gate_pulse_pin1(pin1),
        .gateOpen(gateOpen), .gatePin0Used(pin0Used), .gatePin1Used(pin1Used));
    ifgc_source SRC (.clk(clk), .run(run), .amOut(amIn), .fmOut(fmIn), .pin0Out(pin0),
        .pin1Out(pin1));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bw(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : bw
    task automatic rchk(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] d;
        @(posedge clk);
        busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        d = readData;
        chk(d, ((d >= lo && d <= hi) === 1'b1) ? d : lo);
    endtask : rchk
    task automatic waitGate;
        int n;
        #1;
        chk({15'h0000, gateOpen}, 16'h0001);
        n = 0;
        while (gateOpen !== 1'b0 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({15'h0000, gateOpen}, 16'h0000);
    endtask : waitGate
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500000;
        error_cnt++;
        end_sim();
    end
    initial begin
        busReq = '0;
        softRst = 3'h0;
        run = 1'b0;
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        run <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(8'h20 + 8'(i), 16'h0000, 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            bw(`IFGC_OFS_MODE_SEL, {12'h000, rows[i].mode});
            bw(`IFGC_OFS_CHAN_SEL, {14'h0000, rows[i].chan});
            bw(`IFGC_OFS_CONTROL, 16'h0003);
            waitGate();
            rchk(`IFGC_OFS_COUNT, rows[i].lo, rows[i].hi);
        end
        $display("test table done");
        bw(`IFGC_OFS_CONTROL, 16'h0000);
        rchk(`IFGC_OFS_COUNT, 16'h003B, 16'h003D);
        bw(`IFGC_OFS_CONTROL, 16'h0001);
        repeat (50) @(posedge clk);
        rchk(`IFGC_OFS_COUNT, 16'h0000, 16'h0000);
        rchk(8'h30, 16'h0000, 16'h0000);
        bw(`IFGC_OFS_CHAN_SEL, 16'h000E);
        rchk(`IFGC_OFS_CHAN_SEL, 16'h0002, 16'h0002);
        chk({15'h0000, pin1Used}, 16'h0001);
        $display("test clear done");
        for (int i = 0; i < 3; i++) begin
            bw(`IFGC_OFS_MODE_SEL, 16'h0000);
            bw(`IFGC_OFS_CHAN_SEL, 16'h0001);
            bw(`IFGC_OFS_CONTROL, 16'h0002);
            @(posedge clk);
            #1;
            chk({15'h0000, pin0Used}, 16'h0001);
            chk({15'h0000, gateOpen}, 16'h0001);
            @(posedge clk);
            softRst <= 3'(1 << i);
            @(posedge clk);
            softRst <= 3'h0;
            rchk(`IFGC_OFS_CHAN_SEL, 16'h0000, 16'h0000);
            chk({15'h0000, pin0Used}, 16'h0000);
            chk({15'h0000, gateOpen}, 16'h0000);
        end
        $display("test soft reset done");
        bw(`IFGC_OFS_MODE_SEL, 16'h0007);
        bw(`IFGC_OFS_CONTROL, 16'h0001);
        repeat (100) @(posedge clk);
        rchk(`IFGC_OFS_COUNT, 16'h0018, 16'h001B);
        chk({15'h0000, gateOpen}, 16'h0000);
        $display("test open gate done");
        end_sim();
    end
endmodule : ifgc_counter_bench
`default_nettype wire
